// ---- sad_sequencer.sv ----
// Purpose: Conversion sequencer, result store and bus slave of a 64-channel scanning converter
// Assumes: Classic Wishbone slave, 16-bit data, address modifier on WB_TGA_I, IACK on WB_TGC_I
// Notes: Jumpers and converter pins pass a three-stage synchroniser
//
// What this block does
// RULE1: Reset puts the sequencer in continuous autoscan; software may choose it later.
// RULE2: Autoscan converts enabled channels forever, each into its own 16-bit word.
// RULE3: Host uses autoscan only at gain one with sixteen or more channels.
// RULE4: Scan length is set by jumper from 2 to 64 channels.
// RULE5: Random poll: host starts one conversion, end-of-conversion flag then sets.
// RULE6: Random interrupt: as random poll, plus a bus interrupt at the end.
// RULE7: Scan poll: one scan of enabled channels, then end-of-scan flag sets.
// RULE8: Scan interrupt: one scan, then an end-of-scan interrupt.
// RULE9: Test autoscan scans all channels, one of three references on channel 0.
// RULE10: Three 16-bit timers, cascadable to 48 bits, trigger scans periodically.
// RULE11: An external trigger input can also start a scan.
// RULE12: Interrupts go to any bus level 1 to 7, set by software.
// RULE13: Address bits 15..8 match jumper base; window is 256 bytes.
// RULE14: Address modifier jumpers allow user, supervisor or both short I/O.
// RULE15: 12-bit result in low bits, coded per mode, sign copied to bits 15..12.
// RULE16: Diagnostic lamp lights at reset, stays lit until software clears it.
// RULE17: Result words read at any time, returning the newest stored value.
// RULE18: Interrupt request drops when the host acknowledges it.
// RULE19: Bus is 16-bit address and 16-bit data only.
// RULE20: Each conversion gets 15 us and the channel rate stays at or below 33 kHz.
// RULE21: High gain gets 28 us acquisition and a rate at or below 23 kHz.
// RULE22: Starting a conversion or scan clears its completion flag.
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sad_consts.svh"
module sad_sequencer (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [15:0] WB_ADR_I,
	input wire logic [1:0] WB_SEL_I,
	input wire logic [15:0] WB_DAT_I,
	input wire logic [5:0] WB_TGA_I,
	input wire logic WB_TGC_I,
	output logic [15:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic WB_ERR_O,
	input wire logic [7:0] JMP_BASE,
	input wire logic [1:0] JMP_AM_SEL,
	input wire logic [5:0] JMP_SCAN_LAST,
	input wire logic JMP_HIGH_GAIN,
	input wire logic EXT_TRIG,
	input wire logic [11:0] ADC_DATA,
	output logic [5:0] ADC_CHAN,
	output logic ADC_START,
	output logic ADC_REF_EN,
	output logic [1:0] ADC_REF_SEL,
	output logic [6:0] IRQ_REQ,
	output logic LED_ON
);
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int ACQ_N = (`SAD_ACQ_NS * `SAD_CLK_MHZ + 999) / 1000;
	localparam int ACQ_HG_N = (`SAD_ACQ_HG_NS * `SAD_CLK_MHZ + 999) / 1000;
	localparam int CONV_N = (`SAD_CONV_NS * `SAD_CLK_MHZ + 999) / 1000;
	localparam int SLOT_N = (`SAD_CLK_MHZ * 1000000 + `SAD_RATE_HZ - 1) / `SAD_RATE_HZ;
	localparam int SLOT_HG_N = (`SAD_CLK_MHZ * 1000000 + `SAD_RATE_HG_HZ - 1) / `SAD_RATE_HG_HZ;
	// Acquisition is stretched so that acquire, convert and store never beat the rate cap
	localparam int ACQ_L = ((ACQ_N > SLOT_N - CONV_N - 1) ? ACQ_N : SLOT_N - CONV_N - 1) - 1;
	localparam int ACQ_HG_L = ((ACQ_HG_N > SLOT_HG_N - CONV_N - 1) ? ACQ_HG_N :
		SLOT_HG_N - CONV_N - 1) - 1;
	localparam int CONV_L = CONV_N - 1;

	sad_pkg::sad_state_t st_reg;
	sad_pkg::sad_state_t st_next;
	sad_pkg::sad_tmr_t t0;
	sad_pkg::sad_tmr_t t1;
	sad_pkg::sad_tmr_t t2;
	logic [15:0] mem_rd;
	logic [15:0] res_word;
	logic mem_we;
	logic [5:0] scan_last;
	logic am_ok;
	logic win;
	logic iack_hit;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Converter delivers offset binary; recode and copy the sign upward
	function automatic logic [15:0] sad_fmt(input logic [11:0] raw, input logic [1:0] code);
		logic [11:0] tw;
		tw = {~raw[11], raw[10:0]};
		case (code)
			sad_pkg::SAD_OFFS: sad_fmt = {{4{~raw[11]}}, raw};
			sad_pkg::SAD_TWOS: sad_fmt = {{4{tw[11]}}, tw};
			default: sad_fmt = {4'h0, raw};
		endcase
	endfunction

	// One down-counter of the timer chain; reloads when it expires
	function automatic sad_pkg::sad_tmr_t sad_tmr_step(input logic [15:0] cnt,
		input logic [15:0] rld, input logic tick);
		sad_tmr_step.exp = tick && (cnt == 16'h0000);
		if (!tick) begin
			sad_tmr_step.nxt = cnt;
		end else if (cnt == 16'h0000) begin
			sad_tmr_step.nxt = rld;
		end else begin
			sad_tmr_step.nxt = 16'(cnt - 16'h0001);
		end
	endfunction

	// Level 0 disables; levels 1..7 map to request lines 0..6
	function automatic logic [6:0] sad_lvl_line(input logic [2:0] lvl);
		sad_lvl_line = (lvl == 3'h0) ? 7'h00 : 7'(7'h01 << (lvl - 3'h1));
	endfunction

	// ----------------------------------------
	// Result store
	// ----------------------------------------
	assign mem_we = (st_reg.fsm == sad_pkg::SAD_STORE);
	assign res_word = sad_fmt(st_reg.pin_ok.adc_data, st_reg.ctrl.code); // [RULE15]
	sad_result_ram #(.DEPTH(64), .WIDTH(16), .AW(6)) u_ram (
		.CLOCK(CLOCK),
		.SYS_RST(SYS_RST),
		.wr_en(mem_we),
		.wr_addr(st_reg.chan),
		.wr_data(res_word),
		.rd_addr(WB_ADR_I[6:1]),
		.rd_data(mem_rd)
	); // [RULE2] [RULE17]

	// Decode of window, modifier and acknowledge cycle
	assign am_ok = ((WB_TGA_I == `SAD_AM_SUP) && st_reg.pin_ok.am_sel[1]) ||
		((WB_TGA_I == `SAD_AM_USR) && st_reg.pin_ok.am_sel[0]); // [RULE14]
	assign win = (WB_ADR_I[15:8] == st_reg.pin_ok.base) && am_ok; // [RULE13]
	assign iack_hit = st_reg.irq_pend && (st_reg.irq_lvl != 3'h0) &&
		(WB_ADR_I[3:1] == st_reg.irq_lvl);
	// Test mode always sweeps the whole board; a jumper value of zero is raised to one, so at least two channels scan
	assign scan_last = (st_reg.ctrl.mode == sad_pkg::SAD_BIT) ? `SAD_CHAN_ALL :
		(st_reg.pin_ok.scan_last < `SAD_CHAN_MIN) ? `SAD_CHAN_MIN :
		st_reg.pin_ok.scan_last; // [RULE4] [RULE9]

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic cmd_conv, cmd_scan, trig, cont, go;
		logic [8:0] acq_l;
		logic [7:0] ofs;
		cmd_conv = 1'b0;
		cmd_scan = 1'b0;
		trig = 1'b0;
		cont = 1'b0;
		go = 1'b0;
		acq_l = 9'h000;
		ofs = WB_ADR_I[7:0];
		st_next = st_reg;
		// Pins: a bit changes once the second and third stages agree
		st_next.pin_s1 = {EXT_TRIG, ADC_DATA, JMP_BASE, JMP_AM_SEL, JMP_SCAN_LAST, JMP_HIGH_GAIN};
		st_next.pin_s2 = st_reg.pin_s1;
		st_next.pin_s3 = st_reg.pin_s2;
		st_next.pin_ok = (~(st_reg.pin_s2 ^ st_reg.pin_s3) & st_reg.pin_s2) |
			((st_reg.pin_s2 ^ st_reg.pin_s3) & st_reg.pin_ok);
		st_next.trig_prev = st_reg.pin_ok.ext_trig;
		st_next.adc_start = 1'b0;
		st_next.ack = 1'b0;
		st_next.err = 1'b0;
		// Timer chain; cascading feeds one stage from the expiry of the one before
		t0 = sad_tmr_step(st_reg.tmr_cnt[0], st_reg.tmr_rld[0], 1'b1);
		t1 = sad_tmr_step(st_reg.tmr_cnt[1], st_reg.tmr_rld[1],
			st_reg.tmr_casc[0] ? t0.exp : 1'b1);
		t2 = sad_tmr_step(st_reg.tmr_cnt[2], st_reg.tmr_rld[2],
			st_reg.tmr_casc[1] ? t1.exp : 1'b1); // [RULE10]
		st_next.tmr_cnt = {t2.nxt, t1.nxt, t0.nxt};
		trig = (st_reg.ctrl.trg_tmr && t2.exp) ||
			(st_reg.ctrl.trg_ext && st_reg.pin_ok.ext_trig && !st_reg.trig_prev); // [RULE10] [RULE11]

		// Bus: latch a request, answer it on the following edge
		if (WB_CYC_I && WB_STB_I && !st_reg.ack && !st_reg.err && !st_reg.pend &&
			(WB_TGC_I ? iack_hit : win)) begin
			st_next.pend = 1'b1;
			st_next.pend_iack = WB_TGC_I;
			st_next.pend_err = !WB_TGC_I && (WB_SEL_I != 2'h3); // [RULE19]
		end
		if (st_reg.pend) begin
			st_next.pend = 1'b0;
			st_next.err = st_reg.pend_err;
			st_next.ack = !st_reg.pend_err;
			st_next.dat = 16'h0000;
			if (st_reg.pend_iack) begin
				st_next.dat = {8'h00, st_reg.irq_vec};
				st_next.irq_pend = 1'b0; // [RULE18]
			end else if (!WB_WE_I && !st_reg.pend_err) begin
				case (ofs)
					`SAD_OFS_CTRL: st_next.dat = 16'(st_reg.ctrl);
					`SAD_OFS_STAT: st_next.dat = {2'h0, st_reg.chan, 4'h0, st_reg.irq_pend,
						(st_reg.fsm != sad_pkg::SAD_IDLE), st_reg.eos, st_reg.eoc};
					`SAD_OFS_IRQ: st_next.dat = {st_reg.irq_vec, 5'h00, st_reg.irq_lvl};
					`SAD_OFS_TMR0: st_next.dat = st_reg.tmr_rld[0];
					`SAD_OFS_TMR1: st_next.dat = st_reg.tmr_rld[1];
					`SAD_OFS_TMR2: st_next.dat = st_reg.tmr_rld[2];
					`SAD_OFS_TCTL: st_next.dat = {14'h0000, st_reg.tmr_casc};
					default: st_next.dat = (ofs < `SAD_OFS_RES_END) ? mem_rd : 16'h0000; // [RULE17]
				endcase
			end else if (!st_reg.pend_err) begin
				case (ofs)
					`SAD_OFS_CTRL: begin
						st_next.ctrl = sad_pkg::sad_ctrl_t'(WB_DAT_I); // [RULE1] [RULE16]
						st_next.ctrl.pad = 6'h00;
					end
					`SAD_OFS_CMD: begin
						cmd_conv = WB_DAT_I[`SAD_CMD_CONV];
						cmd_scan = WB_DAT_I[`SAD_CMD_SCAN];
					end
					`SAD_OFS_IRQ: begin
						st_next.irq_lvl = WB_DAT_I[2:0]; // [RULE12]
						st_next.irq_vec = WB_DAT_I[`SAD_VEC_LSB +: 8];
					end
					`SAD_OFS_TMR0: begin
						st_next.tmr_rld[0] = WB_DAT_I;
						st_next.tmr_cnt[0] = WB_DAT_I;
					end
					`SAD_OFS_TMR1: begin
						st_next.tmr_rld[1] = WB_DAT_I;
						st_next.tmr_cnt[1] = WB_DAT_I;
					end
					`SAD_OFS_TMR2: begin
						st_next.tmr_rld[2] = WB_DAT_I;
						st_next.tmr_cnt[2] = WB_DAT_I;
					end
					`SAD_OFS_TCTL: st_next.tmr_casc = WB_DAT_I[1:0];
				endcase
			end
		end

		// Sequencer
		cont = (st_reg.ctrl.mode == sad_pkg::SAD_AUTO) || (st_reg.ctrl.mode == sad_pkg::SAD_BIT);
		acq_l = st_reg.pin_ok.high_gain ? 9'(ACQ_HG_L) : 9'(ACQ_L); // [RULE20] [RULE21]
		unique case (st_reg.fsm)
			sad_pkg::SAD_IDLE: begin
				if (cont) begin
					st_next.chan = 6'h00; // [RULE1] [RULE2]
					go = 1'b1;
				end else if (cmd_conv && ((st_reg.ctrl.mode == sad_pkg::SAD_RPOLL) ||
					(st_reg.ctrl.mode == sad_pkg::SAD_RIRQ))) begin
					st_next.chan = WB_DAT_I[`SAD_CHAN_LSB +: 6]; // [RULE5]
					st_next.eoc = 1'b0; // [RULE22]
					go = 1'b1;
				end else if ((cmd_scan || trig) && ((st_reg.ctrl.mode == sad_pkg::SAD_SPOLL) ||
					(st_reg.ctrl.mode == sad_pkg::SAD_SIRQ))) begin
					st_next.chan = 6'h00;
					st_next.scan_act = 1'b1;
					st_next.eos = 1'b0; // [RULE22]
					go = 1'b1;
				end
			end
			sad_pkg::SAD_ACQ: begin
				if (st_reg.cnt == 9'h000) begin
					st_next.adc_start = 1'b1;
					st_next.cnt = 9'(CONV_L); // [RULE20]
					st_next.fsm = sad_pkg::SAD_CONV;
				end else begin
					st_next.cnt = 9'(st_reg.cnt - 9'h001);
				end
			end
			sad_pkg::SAD_CONV: begin
				if (st_reg.cnt == 9'h000) begin
					st_next.fsm = sad_pkg::SAD_STORE;
				end else begin
					st_next.cnt = 9'(st_reg.cnt - 9'h001);
				end
			end
			sad_pkg::SAD_STORE: begin
				if (cont || (st_reg.scan_act && (st_reg.chan != scan_last))) begin
					st_next.chan = (st_reg.chan == scan_last) ? 6'h00 :
						6'(st_reg.chan + 6'h01); // [RULE2] [RULE4]
					go = 1'b1;
				end else if (st_reg.scan_act) begin
					st_next.scan_act = 1'b0;
					st_next.eos = 1'b1; // [RULE7]
					st_next.fsm = sad_pkg::SAD_IDLE;
					if (st_reg.ctrl.mode == sad_pkg::SAD_SIRQ && st_reg.irq_lvl != 3'h0) begin
						st_next.irq_pend = 1'b1; // [RULE8]
					end
				end else begin
					st_next.eoc = 1'b1; // [RULE5]
					st_next.fsm = sad_pkg::SAD_IDLE;
					if (st_reg.ctrl.mode == sad_pkg::SAD_RIRQ && st_reg.irq_lvl != 3'h0) begin
						st_next.irq_pend = 1'b1; // [RULE6]
					end
				end
			end
		endcase
		if (go) begin
			st_next.fsm = sad_pkg::SAD_ACQ;
			st_next.cnt = acq_l;
		end
		// Reference is routed only while test mode addresses channel 0
		st_next.ref_en = (st_next.ctrl.mode == sad_pkg::SAD_BIT) && (st_next.chan == 6'h00); // [RULE9]
		st_next.irq_out = st_next.irq_pend ? sad_lvl_line(st_next.irq_lvl) : 7'h00; // [RULE12]
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			st_reg <= '0;
			st_reg.ctrl <= sad_pkg::sad_ctrl_t'(`SAD_CTRL_RST); // [RULE1] [RULE16]
			st_reg.tmr_rld <= {3{`SAD_TMR_RST}};
			st_reg.tmr_cnt <= {3{`SAD_TMR_RST}};
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign WB_DAT_O = st_reg.dat;
	assign WB_ACK_O = st_reg.ack;
	assign WB_ERR_O = st_reg.err;
	assign ADC_CHAN = st_reg.chan;
	assign ADC_START = st_reg.adc_start;
	assign ADC_REF_EN = st_reg.ref_en;
	assign ADC_REF_SEL = st_reg.ctrl.ref_sel;
	assign IRQ_REQ = st_reg.irq_out;
	assign LED_ON = st_reg.ctrl.led_on;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	chk_reset_auto: assert property ($past(SYS_RST) |-> // [RULE1] [RULE16]
		st_reg.ctrl.mode == sad_pkg::SAD_AUTO && LED_ON) else $error("reset state wrong");
	chk_auto_wrap: assert property (mem_we && st_reg.ctrl.mode == sad_pkg::SAD_AUTO && // [RULE2]
		st_reg.chan == scan_last |=> ADC_CHAN == 6'h00 && st_reg.fsm == sad_pkg::SAD_ACQ)
		else $error("autoscan did not wrap");
	chk_acq_load: assert property (st_reg.fsm == sad_pkg::SAD_ACQ && // [RULE20] [RULE21]
		$past(st_reg.fsm) != sad_pkg::SAD_ACQ |-> st_reg.cnt ==
		(st_reg.pin_ok.high_gain ? 9'(ACQ_HG_L) : 9'(ACQ_L))) else $error("acquire time wrong");
	chk_conv_load: assert property (ADC_START |-> st_reg.cnt == 9'(CONV_L) && // [RULE20]
		st_reg.fsm == sad_pkg::SAD_CONV) else $error("conversion time wrong");
	chk_eoc_poll: assert property (mem_we && !st_reg.scan_act && // [RULE5]
		st_reg.ctrl.mode == sad_pkg::SAD_RPOLL |=> st_reg.eoc && st_reg.fsm == sad_pkg::SAD_IDLE)
		else $error("end of conversion missing");
	chk_rand_irq: assert property (mem_we && !st_reg.scan_act && // [RULE6] [RULE12]
		st_reg.ctrl.mode == sad_pkg::SAD_RIRQ && st_reg.irq_lvl != 3'h0 |=>
		IRQ_REQ == sad_lvl_line(st_reg.irq_lvl)) else $error("conversion interrupt missing");
	chk_scan_end: assert property (mem_we && st_reg.scan_act && st_reg.chan == scan_last && // [RULE7]
		st_reg.ctrl.mode == sad_pkg::SAD_SPOLL |=> st_reg.eos && st_reg.fsm == sad_pkg::SAD_IDLE)
		else $error("end of scan missing");
	chk_scan_irq: assert property (mem_we && st_reg.scan_act && st_reg.chan == scan_last && // [RULE8]
		st_reg.ctrl.mode == sad_pkg::SAD_SIRQ && st_reg.irq_lvl != 3'h0 |=> IRQ_REQ != 7'h00)
		else $error("scan interrupt missing");
	chk_bit_ref: assert property (ADC_REF_EN |-> ADC_CHAN == 6'h00 && // [RULE9]
		st_reg.ctrl.mode == sad_pkg::SAD_BIT) else $error("reference on wrong channel");
	chk_iack_drop: assert property ($past(st_reg.pend && st_reg.pend_iack) && // [RULE18]
		$past(st_reg.fsm) != sad_pkg::SAD_STORE |-> WB_ACK_O && !st_reg.irq_pend ##1 IRQ_REQ == 7'h00)
		else $error("request not released");
	chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held"); // [RULE19]
	chk_sign_ext: assert property (mem_we && st_reg.ctrl.code == sad_pkg::SAD_TWOS |-> // [RULE15]
		res_word[15:12] == {4{res_word[11]}} && res_word[11] == !st_reg.pin_ok.adc_data[11])
		else $error("sign not extended");
	chk_start_clear: assert property (st_reg.fsm == sad_pkg::SAD_ACQ && // [RULE22]
		$past(st_reg.fsm) == sad_pkg::SAD_IDLE && st_reg.scan_act |-> !st_reg.eos)
		else $error("scan flag not cleared");
	chk_window_hit: assert property ($rose(st_reg.pend) && !$past(WB_TGC_I) |-> // [RULE13]
		$past(WB_ADR_I[15:8]) == $past(st_reg.pin_ok.base)) else $error("foreign address taken");
endmodule
`default_nettype wire

// ---- sad_consts.svh ----
// Purpose: Offsets, field positions, reset values and timing figures of the scan sequencer
// Assumes: Byte offsets inside the 256-byte short I/O window, 16-bit registers
// Notes: Definitions only
`ifndef SAD_CONSTS_SVH
`define SAD_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SAD_OFS_RES_END 8'h80
`define SAD_OFS_CTRL 8'h80
`define SAD_OFS_STAT 8'h82
`define SAD_OFS_CMD 8'h84
`define SAD_OFS_IRQ 8'h86
`define SAD_OFS_TMR0 8'h88
`define SAD_OFS_TMR1 8'h8a
`define SAD_OFS_TMR2 8'h8c
`define SAD_OFS_TCTL 8'h8e
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SAD_CMD_CONV 0
`define SAD_CMD_SCAN 1
`define SAD_CHAN_LSB 8
`define SAD_VEC_LSB 8
// ----------------------------------------
// Reset values and bus codes
// ----------------------------------------
`define SAD_CTRL_RST 16'h0080
`define SAD_TMR_RST 16'hffff
`define SAD_AM_USR 6'h29
`define SAD_AM_SUP 6'h2d
`define SAD_CHAN_MIN 6'h01
`define SAD_CHAN_ALL 6'h3f
// ----------------------------------------
// Timing
// ----------------------------------------
`define SAD_CLK_MHZ 10
`define SAD_ACQ_NS 15000
`define SAD_ACQ_HG_NS 28000
`define SAD_CONV_NS 15000
`define SAD_RATE_HZ 33000
`define SAD_RATE_HG_HZ 23000
`endif

// ---- sad_pkg.sv ----
// Purpose: Types shared by the scan sequencer files
// Assumes: Nothing beyond SystemVerilog packed types
// Notes: Sequencer state is one packed struct
package sad_pkg;
	typedef enum logic [2:0] {
		SAD_AUTO = 3'h0,
		SAD_RPOLL = 3'h1,
		SAD_RIRQ = 3'h2,
		SAD_SPOLL = 3'h3,
		SAD_SIRQ = 3'h4,
		SAD_BIT = 3'h5
	} sad_mode_t;
	typedef enum logic [1:0] {
		SAD_IDLE = 2'h0,
		SAD_ACQ = 2'h1,
		SAD_CONV = 2'h3,
		SAD_STORE = 2'h2
	} sad_fsm_t;
	typedef enum logic [1:0] {SAD_BIN = 2'h0, SAD_OFFS = 2'h1, SAD_TWOS = 2'h2} sad_code_t;
	typedef struct packed {
		logic [5:0] pad;
		logic trg_ext;
		logic trg_tmr;
		logic led_on;
		logic [1:0] ref_sel;
		logic [1:0] code;
		logic [2:0] mode;
	} sad_ctrl_t;
	typedef struct packed {
		logic ext_trig;
		logic [11:0] adc_data;
		logic [7:0] base;
		logic [1:0] am_sel;
		logic [5:0] scan_last;
		logic high_gain;
	} sad_pins_t;
	typedef struct packed {
		logic exp;
		logic [15:0] nxt;
	} sad_tmr_t;
	typedef struct packed {
		sad_pins_t pin_s1;
		sad_pins_t pin_s2;
		sad_pins_t pin_s3;
		sad_pins_t pin_ok;
		logic trig_prev;
		sad_ctrl_t ctrl;
		logic [2:0] irq_lvl;
		logic [7:0] irq_vec;
		logic [2:0][15:0] tmr_rld;
		logic [2:0][15:0] tmr_cnt;
		logic [1:0] tmr_casc;
		sad_fsm_t fsm;
		logic [8:0] cnt;
		logic [5:0] chan;
		logic scan_act;
		logic eoc;
		logic eos;
		logic irq_pend;
		logic adc_start;
		logic ref_en;
		logic [6:0] irq_out;
		logic pend;
		logic pend_iack;
		logic pend_err;
		logic ack;
		logic err;
		logic [15:0] dat;
	} sad_state_t;
endpackage

// ---- sad_result_ram.sv ----
// Purpose: Dual-port result store, one word per channel
// Assumes: One write port from the sequencer, one read port for the bus
// Notes: Read data come out of a register one edge after the address
`timescale 1ns/10ps
`default_nettype none
module sad_result_ram #(
	parameter int DEPTH = 64,
	parameter int WIDTH = 16,
	parameter int AW = 6
) (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0] rd;
	} sad_ram_state_t;
	sad_ram_state_t st_reg;
	sad_ram_state_t st_next;
	// A read of the word being written returns the old value; the next read sees the new one
	always_comb begin
		st_next = st_reg;
		st_next.rd = st_reg.mem[rd_addr];
		if (wr_en) begin
			st_next.mem[wr_addr] = wr_data;
		end
	end
	// State register
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign rd_data = st_reg.rd;
endmodule
`default_nettype wire

// ---- sad_adc_model.sv ----
// Purpose: Converter model that answers the sequencer's start pulses
// Assumes: Result is wanted some 150 cycles after the start pulse
// Notes: Outside a conversion the data lines toggle, so a stale sample shows
`timescale 1ns/10ps
`default_nettype none
module sad_adc_model (
	input wire logic CLOCK,
	input wire logic ADC_START,
	input wire logic [5:0] ADC_CHAN,
	input wire logic ADC_REF_EN,
	input wire logic [1:0] ADC_REF_SEL,
	output logic [11:0] ADC_DATA
);
	logic [7:0] hold;
	initial begin
		hold = 8'h00;
		ADC_DATA = 12'h000;
	end
	// Channel code (or reference code) held through the conversion, junk after it
	always @(posedge CLOCK) begin
		if (ADC_START) begin
			hold <= 8'ha0;
			ADC_DATA <= ADC_REF_EN ? {10'h3c0, ADC_REF_SEL} : {ADC_CHAN, ~ADC_CHAN};
		end else if (hold != 8'h00)
			hold <= hold - 8'h01;
		else
			ADC_DATA <= ~ADC_DATA;
	end
endmodule
`default_nettype wire

// ---- sad_sequencer_tb.sv ----
// Purpose: Self-checking bench of the scan sequencer
// Assumes: Base jumper c0, supervisor only, 16 channels, gain one except in one random-poll test
// Notes: The 4904-cycle waits cover one whole 16-channel scan pass of 304-cycle slots
`timescale 1ns/10ps
`default_nettype none
module sad_sequencer_tb;
	logic clk, rst, cyc, stb, we, tgc, ext_trig, ack, err, adc_start, ref_en, led_on, hg;
	logic [15:0] adr, wdat, rdat, dat_o;
	logic [1:0] sel, ans, ref_sel;
	logic [5:0] tga, chan;
	logic [11:0] adc_data;
	logic [6:0] irq_req;
	int failures = 0, total_checks = 0, cycles = 0, i;
	logic [15:0] row_adr [5] = '{16'hc080, 16'hc000, 16'hc002, 16'hc01e, 16'hc090};
	logic [15:0] row_exp [5] = '{16'h0080, 16'h003f, 16'h007e, 16'h03f0, 16'h0000};
	// Sixteen channels; high gain only in a random mode, so autoscan stays legal
	sad_sequencer i_sad_sequencer (.CLOCK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_TGA_I(tga),
		.WB_TGC_I(tgc), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .WB_ERR_O(err),
		.JMP_BASE(8'hc0), .JMP_AM_SEL(2'b10), .JMP_SCAN_LAST(6'h0f), .JMP_HIGH_GAIN(hg),
		.EXT_TRIG(ext_trig), .ADC_DATA(adc_data), .ADC_CHAN(chan), .ADC_START(adc_start),
		.ADC_REF_EN(ref_en), .ADC_REF_SEL(ref_sel), .IRQ_REQ(irq_req), .LED_ON(led_on));
	sad_adc_model i_sad_adc_model (.CLOCK(clk), .ADC_START(adc_start), .ADC_CHAN(chan),
		.ADC_REF_EN(ref_en), .ADC_REF_SEL(ref_sel), .ADC_DATA(adc_data));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic results();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Hang guard, well above the longest path through the tests
	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			failures++;
			results();
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One classic cycle; a missing answer leaves ans at zero after 20 edges
	task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d,
		input logic [1:0] s, input logic [5:0] t, input logic g);
		int n;
		n = 0;
		ans = 2'b00;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		tga <= t;
		tgc <= g;
		do begin
			@(posedge clk);
			n++;
		end while (!(ack | err) && n < 20);
		ans = {ack, err};
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		bus(1'b1, a, d, 2'b11, 6'h2d, 1'b0);
		chk("write ack", 16'h0002, {14'h0, ans});
	endtask
	task automatic rd(input logic [15:0] a);
		bus(1'b0, a, 16'h0000, 2'b11, 6'h2d, 1'b0);
		chk("read ack", 16'h0002, {14'h0, ans});
	endtask
	// Poll the status word until the given flag sets, bounded
	task automatic poll(input int b);
		rdat = 16'h0000;
		for (int n = 0; n < 300 && !rdat[b]; n++) begin
			repeat (20) @(posedge clk);
			rd(16'hc082);
		end
	endtask
	initial begin
		{cyc, stb, we, tgc, ext_trig, hg} = 6'h00;
		{adr, wdat, sel, tga} = 40'h0;
		rst = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("lamp at reset", 16'h0001, {15'h0, led_on});
		repeat (4904) @(posedge clk);
		for (i = 0; i < 5; i++) begin
			rd(row_adr[i]);
			chk("row read", row_exp[i], rdat);
		end
		// Awkward bus cases: partial select, user modifier, foreign base
		bus(1'b1, 16'hc080, 16'h0000, 2'b01, 6'h2d, 1'b0);
		chk("partial sel", 16'h0001, {14'h0, ans});
		chk("lamp kept", 16'h0001, {15'h0, led_on});
		bus(1'b0, 16'hc080, 16'h0000, 2'b11, 6'h29, 1'b0);
		chk("user am", 16'h0000, {14'h0, ans});
		bus(1'b0, 16'hc180, 16'h0000, 2'b11, 6'h2d, 1'b0);
		chk("other base", 16'h0000, {14'h0, ans});
		wr(16'hc080, 16'h0000);
		chk("lamp off", 16'h0000, {15'h0, led_on});
		// Offset and two's complement codes of channel 1 (raw 07e)
		for (i = 1; i < 3; i++) begin
			wr(16'hc080, 16'(i << 3));
			repeat (4904) @(posedge clk);
			rd(16'hc002);
			chk("coded", (i == 1) ? 16'hf07e : 16'hf87e, rdat);
		end
		// Test autoscan with reference 2 on channel 0
		wr(16'hc080, 16'h0045);
		for (i = 0; i < 25000 && !(adc_start && chan == 6'h00); i++) @(posedge clk);
		chk("ref route", 16'h0006, {13'h0, ref_en, ref_sel});
		repeat (200) @(posedge clk);
		rd(16'hc000);
		chk("ref result", 16'h0f02, rdat);
		// Single scan by external trigger, restart clears end of scan
		wr(16'hc080, 16'h0203);
		repeat (400) @(posedge clk);
		ext_trig <= 1'b1;
		repeat (8) @(posedge clk);
		ext_trig <= 1'b0;
		poll(1);
		chk("end of scan", 16'h0002, rdat & 16'h0002);
		wr(16'hc084, 16'h0002);
		rd(16'hc082);
		chk("eos cleared", 16'h0000, rdat & 16'h0002);
		poll(1);
		// Random interrupt on channel 5 at level 3, vector 5a
		wr(16'hc086, 16'h5a03);
		wr(16'hc080, 16'h0002);
		wr(16'hc084, 16'h0501);
		for (i = 0; i < 600 && irq_req == 7'h00; i++) @(posedge clk);
		chk("irq level", 16'h0004, {9'h0, irq_req});
		rd(16'hc082);
		chk("end of conv", 16'h0001, rdat & 16'h0001);
		bus(1'b0, 16'h0006, 16'h0000, 2'b11, 6'h2d, 1'b1);
		chk("vector", 16'h005a, rdat);
		repeat (3) @(posedge clk);
		chk("irq released", 16'h0000, {9'h0, irq_req});
		rd(16'hc00a);
		chk("chan 5", 16'h017a, rdat);
		// Highest gain, random poll: 28 us is 280 cycles, 23 kHz stretches acquire to 284
		hg <= 1'b1;
		wr(16'hc080, 16'h0001);
		wr(16'hc084, 16'h0201);
		// Counting starts two edges after the command edge, so 283 edges remain
		for (i = 0; i < 1000 && !adc_start; i++) @(posedge clk);
		chk("long acquire", 16'h011b, 16'(i));
		hg <= 1'b0;
		// Timer 2 paces one scanning-interrupt pass at level 3
		wr(16'hc08c, 16'h0100);
		wr(16'hc080, 16'h0104);
		for (i = 0; i < 8000 && irq_req == 7'h00; i++) @(posedge clk);
		chk("scan irq", 16'h0004, {9'h0, irq_req});
		rd(16'hc082);
		chk("scan done", 16'h000a, rdat & 16'h000a);
		results();
	end
endmodule
`default_nettype wire
